// file: logic/general_port_pins.sv
// Purpose: general port pins with direction, pull-ups and pin interrupts
// Assumes: AHB-Lite slave, zero wait states, pins synchronous to clock
// Notes:   pin vectors are flattened: slot p owns bits p*8+7..p*8
//
// The implementer's own choices: the register addresses and the AHB-Lite interface to the registers.
module general_port_pins (
  input  wire logic        core_clk_in,   // core clock, 10 MHz
  input  wire logic        rst_in,        // async reset, high
  input  wire logic        hsel_in,       // slave select
  input  wire logic [31:0] haddr_in,      // byte address
  input  wire logic [1:0]  htrans_in,     // transfer type
  input  wire logic        hwrite_in,     // write when high
  input  wire logic [2:0]  hsize_in,      // word only
  input  wire logic        hready_in,     // bus ready
  input  wire logic [31:0] hwdata_in,     // write data
  output logic      [31:0] hrdata_out,    // read data
  output logic             hreadyout_out, // slave ready
  output logic             hresp_out,     // always okay
  input  wire logic [79:0] pin_in_in,     // pin levels
  output logic      [79:0] pin_out_out,   // pin drive level
  output logic      [79:0] pin_oe_out,    // pin drive enable
  output logic      [79:0] pullup_out,    // pull-up switched on
  output logic             irq_out        // level interrupt
);
  localparam int NP = gpio_pkg::NPORT;

  logic [7:0]  latch_r [NP];      // output latches
  logic [7:0]  dir_r   [NP];      // direction, 1 = input
  logic [7:0]  pu_r    [NP];      // pull-up requests
  logic [79:0] dir_flat;          // directions, flattened
  logic [79:0] rdpin;             // per-bit read value
  logic        wr_pend_r;         // write data phase pending
  logic [11:0] wadr_r;            // latched write address
  logic [7:0]  analog_r;          // port 1 analog select
  logic [6:0]  rise_r;            // rising edge enables
  logic [6:0]  fall_r;            // falling edge enables
  logic [6:0]  stat_r;            // sticky interrupt flags
  logic [6:0]  mask_r;            // 1 = flag reaches irq_out
  logic [6:0]  prev_r;            // last sampled irq pins
  logic        armed_r;           // prev_r holds a real sample
  logic [6:0]  ev;                // edge events this cycle
  logic [6:0]  clr;               // write-one-to-clear bits
  logic [6:0]  stat_nxt;          // next flag value
  logic [31:0] rd_nxt;            // read data for next cycle

  // address phase: remember writes, answer with no wait states
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      wr_pend_r     <= 1'b0;
      wadr_r        <= 12'h000;
      hreadyout_out <= 1'b0;
      hresp_out     <= 1'b0;
    end else begin
      wr_pend_r     <= hsel_in & hready_in & htrans_in[1] & hwrite_in;
      wadr_r        <= haddr_in[11:0];
      hreadyout_out <= 1'b1;
      hresp_out     <= 1'b0;
    end
  end

  // per-port latches and pin drivers
  genvar p;
  generate
    for (p = 0; p < NP; p++) begin : g_port
      logic [7:0] io;   // bits with an output driver
      logic [7:0] od;   // open-drain bits
      logic [7:0] ana;  // pull-up kill from analog use
      logic       sel;  // write hits this port
      assign io  = gpio_pkg::EXIST_MASK[p*8 +: 8]
                 & ~gpio_pkg::INONLY_MASK[p*8 +: 8];
      assign od  = gpio_pkg::OD_MASK[p*8 +: 8];
      assign ana = (p == gpio_pkg::ANALOG_PORT) ? analog_r : 8'h00;
      assign sel = wr_pend_r && (wadr_r[11:4] == 8'(p));
      assign dir_flat[p*8 +: 8] = dir_r[p];
      // input bits read the pin, output bits read back the latch
      assign rdpin[p*8 +: 8] = ((pin_in_in[p*8 +: 8] & dir_r[p])
                              | (latch_r[p] & ~dir_r[p]))
                              & gpio_pkg::EXIST_MASK[p*8 +: 8];

      // software writes; missing and input-only bits stay input
      always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
          latch_r[p] <= gpio_pkg::LATCH_RST;
          dir_r[p]   <= gpio_pkg::DIR_RST;
          pu_r[p]    <= gpio_pkg::PU_RST;
        end else if (sel) begin
          case (wadr_r[3:0])
            gpio_pkg::LATCH_OFS: latch_r[p] <= hwdata_in[7:0] & io;
            gpio_pkg::DIR_OFS:   dir_r[p] <= hwdata_in[7:0] | ~io;
            gpio_pkg::PU_OFS:    pu_r[p] <= hwdata_in[7:0] & io & ~od;
            default: ;                          // pin read is read-only
          endcase
        end
      end

      // registered pin drive; open-drain bits only ever pull low
      always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
          pin_out_out[p*8 +: 8] <= 8'h00;
          pin_oe_out[p*8 +: 8]  <= 8'h00;
          pullup_out[p*8 +: 8]  <= 8'h00;
        end else begin
          pin_out_out[p*8 +: 8] <= latch_r[p] & ~od;
          pin_oe_out[p*8 +: 8]  <= io & ~dir_r[p]
                                 & (~od | ~latch_r[p]);
          // pull-up only on inputs, never on analog or open-drain bits
          pullup_out[p*8 +: 8]  <= io & ~od & dir_r[p] & pu_r[p]
                                 & ~ana;
        end
      end
    end
  endgenerate

  // edge detection on port 0 bits 0..6
  always_comb begin
    ev  = armed_r ? ((pin_in_in[6:0] & ~prev_r & rise_r)
                  | (~pin_in_in[6:0] & prev_r & fall_r)) : 7'h00;
    clr = (wr_pend_r && wadr_r == gpio_pkg::STAT_ADDR)
        ? hwdata_in[6:0] : 7'h00;
    // a new edge beats a clear in the same cycle
    stat_nxt = (stat_r & ~clr) | ev;
  end

  // pin sampler; arming avoids a false edge out of reset
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      prev_r  <= 7'h00;
      armed_r <= 1'b0;
    end else begin
      prev_r  <= pin_in_in[6:0];
      armed_r <= 1'b1;
    end
  end

  // flags and interrupt line
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      stat_r  <= 7'h00;
      irq_out <= 1'b0;
    end else begin
      stat_r  <= stat_nxt;
      irq_out <= |(stat_nxt & mask_r);
    end
  end

  // global control registers
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      analog_r <= 8'h00;
      rise_r   <= 7'h00;
      fall_r   <= 7'h00;
      mask_r   <= 7'h00;
    end else if (wr_pend_r) begin
      case (wadr_r)
        gpio_pkg::ANALOG_ADDR: analog_r <= hwdata_in[7:0];
        gpio_pkg::RISE_ADDR:   rise_r   <= hwdata_in[6:0];
        gpio_pkg::FALL_ADDR:   fall_r   <= hwdata_in[6:0];
        gpio_pkg::MASK_ADDR:   mask_r   <= hwdata_in[6:0];
        default: ;                              // ports or unmapped
      endcase
    end
  end

  // read decode in the address phase, data out next cycle
  always_comb begin
    rd_nxt = 32'h0000_0000;
    if (haddr_in[11:8] == 4'h0 && haddr_in[7:4] < 4'(NP)) begin
      case (haddr_in[3:0])
        gpio_pkg::LATCH_OFS: rd_nxt[7:0] = latch_r[haddr_in[7:4]];
        gpio_pkg::DIR_OFS:   rd_nxt[7:0] = dir_r[haddr_in[7:4]];
        gpio_pkg::PU_OFS:    rd_nxt[7:0] = pu_r[haddr_in[7:4]];
        gpio_pkg::PIN_OFS:   rd_nxt[7:0] = rdpin[haddr_in[7:4]*8 +: 8];
        default:             rd_nxt = 32'h0000_0000;
      endcase
    end else begin
      case (haddr_in[11:0])
        gpio_pkg::ANALOG_ADDR: rd_nxt[7:0] = analog_r;
        gpio_pkg::RISE_ADDR:   rd_nxt[6:0] = rise_r;
        gpio_pkg::FALL_ADDR:   rd_nxt[6:0] = fall_r;
        gpio_pkg::STAT_ADDR:   rd_nxt[6:0] = stat_r;
        gpio_pkg::MASK_ADDR:   rd_nxt[6:0] = mask_r;
        default:               rd_nxt = 32'h0000_0000;
      endcase
    end
  end

  // read data register
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) hrdata_out <= 32'h0000_0000;
    else if (hsel_in & hready_in & htrans_in[1] & ~hwrite_in)
      hrdata_out <= rd_nxt;
  end

  a_absent_quiet:
  assert property (@(posedge core_clk_in) disable iff (rst_in)
    ((pin_oe_out | pullup_out) & ~gpio_pkg::EXIST_MASK) == 80'h0)
    else $error("absent pin driven or pulled up");

  a_input_no_drive:
  assert property (@(posedge core_clk_in) disable iff (rst_in)
    ##1 (pin_oe_out & $past(dir_flat)) == 80'h0)
    else $error("input bit is driving");

  a_output_drives:
  assert property (@(posedge core_clk_in) disable iff (rst_in)
    ##1 ((~$past(dir_flat) & gpio_pkg::EXIST_MASK & ~gpio_pkg::OD_MASK
      & ~gpio_pkg::INONLY_MASK) & ~pin_oe_out) == 80'h0)
    else $error("output bit not driving");

  a_pullup_input:
  assert property (@(posedge core_clk_in) disable iff (rst_in)
    ##1 (pullup_out & ~$past(dir_flat)) == 80'h0)
    else $error("pull-up on an output bit");

  a_inonly_never:
  assert property (@(posedge core_clk_in) disable iff (rst_in)
    ((pin_oe_out | pullup_out) & gpio_pkg::INONLY_MASK) == 80'h0)
    else $error("input-only bit driven");

  a_analog_pullup:
  assert property (@(posedge core_clk_in) disable iff (rst_in)
    ##1 (pullup_out[15:8] & $past(analog_r)) == 8'h00)
    else $error("pull-up left on analog pin");

  a_edge_flag:
  assert property (@(posedge core_clk_in) disable iff (rst_in)
    ev != 7'h00 |=> (stat_r & $past(ev)) == $past(ev)
      && (irq_out || ($past(ev & mask_r) == 7'h00)))
    else $error("edge did not raise flag");

  a_flag_clear:
  assert property (@(posedge core_clk_in) disable iff (rst_in)
    clr != 7'h00 && ev == 7'h00 |=> (stat_r & $past(clr)) == 7'h00)
    else $error("flag not cleared by write");

  a_reset_inputs:
  assert property (@(posedge core_clk_in)
    $fell(rst_in) |-> pin_oe_out == 80'h0 && pullup_out == 80'h0)
    else $error("pin active after reset");

  a_od_low_only:
  assert property (@(posedge core_clk_in) disable iff (rst_in)
    ((pin_out_out | pullup_out) & gpio_pkg::OD_MASK) == 80'h0)
    else $error("open-drain bit pulled high");
endmodule

// file: logic/gpio_pkg.sv
// Purpose: shared constants of the general port block
// Assumes: ten ports stored as 8-bit slots, pins flattened port by port
// Notes:   slot order is ports 0,1,2,3,4,5,6,7,12,13
package gpio_pkg;
  localparam int NPORT = 10;              // port slots
  localparam int NPIN  = NPORT * 8;       // flattened pin count
  localparam int NIRQ  = 7;               // external interrupt pins
  // bits that physically exist (port 7 has 3, port 13 has 2)
  localparam logic [79:0] EXIST_MASK = {8'h03, 8'hff, 8'h07, {7{8'hff}}};
  // input-only bits of port 0 (bits 0 and 7)
  localparam logic [79:0] INONLY_MASK = 80'h81;
  // open-drain low nibble of port 6
  localparam logic [79:0] OD_MASK = {24'h0, 8'h0f, 48'h0};
  localparam int ANALOG_PORT = 1;         // slot carrying analog inputs
  // register map, byte addresses
  localparam logic [3:0]  LATCH_OFS   = 4'h0;   // output latch
  localparam logic [3:0]  DIR_OFS     = 4'h4;   // 1 = input
  localparam logic [3:0]  PU_OFS      = 4'h8;   // pull-up enable
  localparam logic [3:0]  PIN_OFS     = 4'hc;   // pin level read
  localparam logic [11:0] ANALOG_ADDR = 12'h100;
  localparam logic [11:0] RISE_ADDR   = 12'h104;
  localparam logic [11:0] FALL_ADDR   = 12'h108;
  localparam logic [11:0] STAT_ADDR   = 12'h10c;
  localparam logic [11:0] MASK_ADDR   = 12'h110;
  // values after reset
  localparam logic [7:0] LATCH_RST = 8'h00;
  localparam logic [7:0] DIR_RST   = 8'hff;
  localparam logic [7:0] PU_RST    = 8'h00;
endpackage

// file: dv/pin_world.sv
// Purpose: external circuit model hanging on every port pin
// Assumes: pin drive from the block wins; pull-up beats a floating line
// Notes:   a floating pin flips each cycle so a stale level never passes
module pin_world (
  input  wire logic        clk_in,     // core clock
  input  wire logic [79:0] drive_in,   // block drive level
  input  wire logic [79:0] drive_en_in, // block drive enable
  input  wire logic [79:0] pull_in,    // block pull-up on
  input  wire logic [79:0] ext_en_in,  // bench drives the pin
  input  wire logic [79:0] ext_val_in, // bench level
  output logic      [79:0] level_out   // resolved pin level
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [79:0] last_r = '0;  // previous resolved level
  // open-drain bits only ever see drive level 0 from the block
  always_comb begin
    for (int i = 0; i < 80; i++) begin
      if (drive_en_in[i]) begin
        level_out[i] = drive_in[i];
      end else if (ext_en_in[i]) begin
        level_out[i] = ext_val_in[i];
      end else if (pull_in[i]) begin
        level_out[i] = 1'b1;
      end else begin
        level_out[i] = ~last_r[i];  // undriven: no trustworthy level
      end
    end
  end
  // remember the level so a floating line keeps moving
  always_ff @(posedge clk_in) begin
    last_r <= level_out;
  end
endmodule

// file: dv/tb.sv
// Purpose: register-level test of the general port block
// Assumes: zero-wait bus slave, one-edge output latency
// Notes:   slot 0 bits 0..6 are held by the bench for interrupt tests
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin \
  num_errors++; $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 0, rst = 1, hw = 0;  // clock, reset, write
  logic [1:0]  ht = '0;                   // transfer type
  logic [31:0] ha = '0, hd = '0, rd;      // address, wdata, rdata
  // port 0 bit 7 is never used as a plain input here
  logic [79:0] ext_en = 80'h7f, ext_val = '0;  // bench pin drive
  logic [31:0] want;                      // expected status word
  logic [31:0] hrdata;
  logic        hrdy, hresp, irq;
  logic [79:0] p_out, p_oe, pu, lvl;
  int          num_errors = 0, n_checks = 0;
  always #50 clk = ~clk;
  general_port_pins i_dut (.core_clk_in(clk), .rst_in(rst), .hsel_in(1'b1),
    .haddr_in(ha), .htrans_in(ht), .hwrite_in(hw), .hsize_in(3'b010),
    .hready_in(hrdy), .hwdata_in(hd), .hrdata_out(hrdata),
    .hreadyout_out(hrdy), .hresp_out(hresp), .pin_in_in(lvl),
    .pin_out_out(p_out), .pin_oe_out(p_oe), .pullup_out(pu), .irq_out(irq));
  pin_world i_world (.clk_in(clk), .drive_in(p_out), .drive_en_in(p_oe),
    .pull_in(pu), .ext_en_in(ext_en), .ext_val_in(ext_val), .level_out(lvl));
  task automatic stop_test;
    if (num_errors == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // bounded wait for the slave; a hang ends the run
  task automatic wait_rdy;
    int n;
    n = 0;
    do begin @(posedge clk); n++; end while (hrdy !== 1'b1 && n < 20);
    if (hrdy !== 1'b1) begin num_errors++; stop_test(); end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    ht <= 2'b10; ha <= {20'h0, a}; hw <= 1'b1;
    wait_rdy();
    ht <= 2'b00; hd <= d;
    wait_rdy();
  endtask
  task automatic rdr(input logic [11:0] a, output logic [31:0] d);
    ht <= 2'b10; ha <= {20'h0, a}; hw <= 1'b0;
    wait_rdy();
    ht <= 2'b00;
    wait_rdy();
    d = hrdata;
  endtask
  // one more edge so registered pin outputs land
  task automatic settle;
    @(posedge clk); #1;
  endtask
  function automatic logic [11:0] pa(input int p, input logic [3:0] o);
    return 12'(p * 16) | {8'h0, o};
  endfunction
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    `CHK("oe rst", 80'h0, p_oe)
    `CHK("pu rst", 80'h0, pu)
    for (int p = 0; p < gpio_pkg::NPORT; p++) begin
      rdr(pa(p, gpio_pkg::DIR_OFS), rd);
      `CHK("dir rst", 32'h0000_00ff, rd)
    end
    wr(pa(2, gpio_pkg::DIR_OFS), 32'h5a);
    settle();
    `CHK("oe bitwise", 8'ha5, p_oe[23:16])
    wr(pa(3, gpio_pkg::PU_OFS), 32'hff);
    wr(pa(3, gpio_pkg::DIR_OFS), 32'h0f);
    settle();
    `CHK("pu inputs", 8'h0f, pu[31:24])
    // pulled-up inputs read high, outputs read back their latch
    rdr(pa(3, gpio_pkg::PIN_OFS), rd);
    `CHK("pin p3", 32'h0000_000f, rd)
    wr(pa(3, gpio_pkg::LATCH_OFS), 32'hf0);
    settle();
    `CHK("out p3", 8'hf0, p_out[31:24])
    rdr(pa(3, gpio_pkg::LATCH_OFS), rd);
    `CHK("latch p3", 32'h0000_00f0, rd)
    rdr(pa(3, gpio_pkg::PIN_OFS), rd);
    `CHK("pin p3 out", 32'h0000_00ff, rd)
    for (int p = 0; p < 10; p += 7) begin
      wr(pa(p, gpio_pkg::DIR_OFS), 32'h0);
    end
    wr(pa(9, gpio_pkg::DIR_OFS), 32'h0);
    settle();
    `CHK("oe p0", 8'h7e, p_oe[7:0])
    `CHK("oe p7", 8'h07, p_oe[63:56])
    `CHK("oe p13", 8'h03, p_oe[79:72])
    wr(pa(0, gpio_pkg::DIR_OFS), 32'hff);
    wr(pa(6, gpio_pkg::PU_OFS), 32'hff);
    settle();
    `CHK("pu od", 8'hf0, pu[55:48])
    wr(pa(6, gpio_pkg::LATCH_OFS), 32'h05);
    wr(pa(6, gpio_pkg::DIR_OFS), 32'h0);
    settle();
    `CHK("oe od", 8'hfa, p_oe[55:48])
    `CHK("out od", 4'h0, p_out[51:48])
    wr(pa(1, gpio_pkg::PU_OFS), 32'hff);
    settle();
    `CHK("pu p1", 8'hff, pu[15:8])
    // all of port 1 analog while input; its latch is not touched again
    wr(gpio_pkg::ANALOG_ADDR, 32'hff);
    settle();
    `CHK("pu analog", 8'h00, pu[15:8])
    rdr(12'h200, rd);
    `CHK("unmapped", 32'h0, rd)
    // modes per pin: rise, fall or both
    wr(gpio_pkg::RISE_ADDR, 32'h6d);
    wr(gpio_pkg::FALL_ADDR, 32'h36);
    for (int i = 0; i < gpio_pkg::NIRQ; i++) begin
      for (int v = 1; v >= 0; v--) begin
        ext_val[i] <= v[0];
        repeat (3) @(posedge clk);
        rdr(gpio_pkg::STAT_ADDR, rd);
        want = {25'h0, (v ? 7'h6d : 7'h36) & (7'h1 << i)};
        `CHK("stat", want, rd)
        `CHK("irq masked", 1'b0, irq)
        wr(gpio_pkg::STAT_ADDR, 32'h7f);
      end
    end
    ext_val[2] <= 1'b1;
    repeat (3) @(posedge clk);
    wr(gpio_pkg::MASK_ADDR, 32'h04);
    settle();
    `CHK("irq on", 1'b1, irq)
    wr(gpio_pkg::STAT_ADDR, 32'h04);
    settle();
    `CHK("irq clr", 1'b0, irq)
    // second reset in mid-run: every pin idles again, no false edge
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    `CHK("oe rst2", 80'h0, p_oe)
    `CHK("pu rst2", 80'h0, pu)
    `CHK("irq rst2", 1'b0, irq)
    rdr(pa(3, gpio_pkg::DIR_OFS), rd);
    `CHK("dir rst2", 32'h0000_00ff, rd)
    rdr(gpio_pkg::STAT_ADDR, rd);
    `CHK("stat rst2", 32'h0, rd)
    `CHK("hresp", 1'b0, hresp)
    stop_test();
  end
endmodule
